// ===== hdl/ucm_top.sv
// register interface, command decode and mode decode of the serial transceiver
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module ucm_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_we_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  tx_idle_i,
    input  wire logic                  char_time_i,
    input  wire logic                  bit_tick_i,
    input  wire logic                  rx_char_i,
    input  wire logic [3:0]            err_event_i,
    input  wire logic                  timeout_event_i,
    input  wire logic                  retry_event_i,
    input  wire logic                  nak_event_i,
    input  wire logic [8:0]            rx_data_i,
    input  wire logic                  rx_valid_i,
    input  wire logic [7:0]            err_count_i,
    output ucm_pkg::ucm_ctrl_type      ctrl_o,
    output ucm_pkg::ucm_mode_type      mode_o,
    output logic      [8:0]            tx_data_o,
    output logic                       tx_valid_o,
    output logic      [31:0]           baud_divider_o,
    output logic      [31:0]           idle_timeout_o,
    output logic      [31:0]           guard_time_o,
    output logic      [31:0]           card_ratio_o,
    output logic      [31:0]           ir_filter_o,
    output logic      [31:0]           irq_mask_o
);

    typedef struct packed {
        logic [31:0]          mode_config;
        logic [31:0]          irq_state;
        logic [31:0]          baud;
        logic [31:0]          idle_to;
        logic [31:0]          guard;
        logic [31:0]          card_clk;
        logic [31:0]          ir_filt;
        logic [31:0]          rx_hold;
        logic [3:0]           err_flags;
        logic                 timeout_flag;
        logic                 retry_flag;
        logic                 nak_flag;
        logic                 tx_on;
        logic                 rx_on;
        logic                 addr_pending;
        logic                 tx_reset;
        logic                 rx_reset;
        logic                 to_wait;
        logic                 to_restart;
        logic                 rts_n;
        ucm_pkg::ucm_brk_type brk;
        logic                 brk_min_done;
        logic [3:0]           tail_cnt;
        logic [8:0]           tx_data;
        logic                 tx_valid;
        logic [31:0]          dat;
        logic                 ack;
        ucm_pkg::ucm_mode_type mode;
    } ucm_state_type;

    ucm_state_type st;
    ucm_state_type next_st;

    logic        wr;
    logic        rd;
    logic [31:0] wmask;
    logic [31:0] cmd;

    ////////////////////////////////////////////////////////////////////////////
    // merge a write under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // decode the mode word into the fields the core needs
    function automatic ucm_pkg::ucm_mode_type decode_mode(input logic [31:0] w);
        ucm_pkg::ucm_mode_type m;
        logic                  sync;
        m = '0;
        sync = w[8];
        m.opmode = w[3:0];
        m.mode_valid = (w[3:0] == ucm_pkg::OPM_NORMAL) || (w[3:0] == ucm_pkg::OPM_RS485)
                    || (w[3:0] == ucm_pkg::OPM_HANDSHAKE) || (w[3:0] == ucm_pkg::OPM_CARD_T0)
                    || (w[3:0] == ucm_pkg::OPM_CARD_T1) || (w[3:0] == ucm_pkg::OPM_INFRARED);
        m.card_mode = (w[3:0] == ucm_pkg::OPM_CARD_T0) || (w[3:0] == ucm_pkg::OPM_CARD_T1);
        // reserved source falls back to master clock
        m.baud_source_select = (w[5:4] == ucm_pkg::CLK_RSVD) ? ucm_pkg::CLK_MASTER : w[5:4];
        m.char_bits = w[17] ? 4'h9 : (4'h5 + {2'h0, w[7:6]});
        m.parity_select = w[11:9];
        m.parity_on = ~w[11];
        m.multidrop = w[11] & w[10];
        m.stop_bits_select = w[13:12];
        m.stop_valid = (w[13:12] != 2'h3) && !(sync && (w[13:12] == 2'h1));
        m.channel_loop_mode = w[15:14];
        decode_mode = m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack;
    // command word only lives for the write cycle
    assign cmd = (wr && wb_adr_i == ucm_pkg::OFS_COMMAND) ? (wb_dat_i & wmask) : 32'h0000_0000;

    always_comb
    begin
        next_st = st;
        next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
        next_st.tx_valid = 1'b0;
        next_st.rx_reset = cmd[ucm_pkg::CMD_RX_RESET];
        next_st.tx_reset = cmd[ucm_pkg::CMD_TX_RESET];
        next_st.to_wait = 1'b0;
        next_st.to_restart = 1'b0;

        if (cmd[ucm_pkg::CMD_RX_OFF])
            next_st.rx_on = 1'b0;
        else if (cmd[ucm_pkg::CMD_RX_ON])
            next_st.rx_on = 1'b1;
        if (cmd[ucm_pkg::CMD_TX_OFF])
            next_st.tx_on = 1'b0;
        else if (cmd[ucm_pkg::CMD_TX_ON])
            next_st.tx_on = 1'b1;

        // clear then set, so a same-cycle event survives
        if (cmd[ucm_pkg::CMD_ERR_CLR])
            next_st.err_flags = 4'h0;
        next_st.err_flags = next_st.err_flags | err_event_i;

        if (cmd[ucm_pkg::CMD_TO_WAIT])
        begin
            next_st.timeout_flag = 1'b0;
            next_st.to_wait = 1'b1;
        end
        next_st.to_restart = cmd[ucm_pkg::CMD_TO_RESTART];
        next_st.timeout_flag = next_st.timeout_flag | timeout_event_i;

        if (cmd[ucm_pkg::CMD_RETRY_CLR] && st.mode.card_mode)
            next_st.retry_flag = 1'b0;
        next_st.retry_flag = next_st.retry_flag | retry_event_i;
        if (cmd[ucm_pkg::CMD_NAK_CLR])
            next_st.nak_flag = 1'b0;
        next_st.nak_flag = next_st.nak_flag | nak_event_i;

        // rts pin level, high command wins
        if (cmd[ucm_pkg::CMD_RTS_HIGH])
            next_st.rts_n = 1'b1;
        else if (cmd[ucm_pkg::CMD_RTS_LOW])
            next_st.rts_n = 1'b0;

        if (cmd[ucm_pkg::CMD_ADDR_CHAR] && st.mode.multidrop)
            next_st.addr_pending = 1'b1;
        if (wr && wb_adr_i == ucm_pkg::OFS_TX_HOLD)
        begin
            next_st.tx_data = st.mode.char_bits == 4'h9 ? wb_dat_i[8:0]
                                                       : {st.addr_pending, wb_dat_i[7:0]};
            next_st.tx_valid = 1'b1;
            next_st.addr_pending = 1'b0;
        end

        // break sequencer
        case (st.brk)
            ucm_pkg::BRK_IDLE:
            begin
                if (cmd[ucm_pkg::CMD_BRK_BEGIN] || st.brk_min_done)
                begin
                    next_st.brk_min_done = 1'b1;
                    if (tx_idle_i)
                    begin
                        next_st.brk = ucm_pkg::BRK_SEND;
                        next_st.brk_min_done = 1'b0;
                    end
                end
            end
            ucm_pkg::BRK_SEND:
            begin
                if (char_time_i)
                    next_st.brk_min_done = 1'b1;
                if (cmd[ucm_pkg::CMD_BRK_END])
                    next_st.tail_cnt = 4'h1;
                if ((st.tail_cnt != 4'h0 || cmd[ucm_pkg::CMD_BRK_END])
                    && (st.brk_min_done || char_time_i))
                begin
                    next_st.brk = ucm_pkg::BRK_TAIL;
                    next_st.tail_cnt = ucm_pkg::BRK_TAIL_BITS;
                    next_st.brk_min_done = 1'b0;
                end
            end
            ucm_pkg::BRK_TAIL:
            begin
                if (bit_tick_i)
                    next_st.tail_cnt = st.tail_cnt - 4'h1;
                if (bit_tick_i && st.tail_cnt == 4'h1)
                    next_st.brk = ucm_pkg::BRK_IDLE;
            end
            default:
                next_st.brk = ucm_pkg::BRK_IDLE;
        endcase

        if (rx_valid_i)
            next_st.rx_hold = {23'h0, rx_data_i};

        // register writes
        if (wr)
        begin
            case (wb_adr_i)
                ucm_pkg::OFS_MODE:
                    next_st.mode_config = merge(st.mode_config, wb_dat_i,
                                                wmask & ucm_pkg::MODE_WMASK);
                ucm_pkg::OFS_IRQ_SET:
                    next_st.irq_state = st.irq_state | (wb_dat_i & wmask & ucm_pkg::IRQ_WMASK);
                ucm_pkg::OFS_IRQ_CLR:
                    next_st.irq_state = st.irq_state & ~(wb_dat_i & wmask);
                ucm_pkg::OFS_BAUD:     next_st.baud = merge(st.baud, wb_dat_i, wmask);
                ucm_pkg::OFS_IDLE_TO:  next_st.idle_to = merge(st.idle_to, wb_dat_i, wmask);
                ucm_pkg::OFS_GUARD:    next_st.guard = merge(st.guard, wb_dat_i, wmask);
                ucm_pkg::OFS_CARD_CLK: next_st.card_clk = merge(st.card_clk, wb_dat_i, wmask);
                ucm_pkg::OFS_IR_FILT:  next_st.ir_filt = merge(st.ir_filt, wb_dat_i, wmask);
                default: ;
            endcase
        end
        next_st.mode = decode_mode(next_st.mode_config);

        // read decode, zero for anything unmapped
        next_st.dat = 32'h0000_0000;
        if (rd)
        begin
            case (wb_adr_i)
                ucm_pkg::OFS_MODE:      next_st.dat = st.mode_config;
                ucm_pkg::OFS_IRQ_STATE: next_st.dat = st.irq_state;
                ucm_pkg::OFS_FLAGS:
                begin
                    next_st.dat[ucm_pkg::FLG_RX_BREAK] = st.err_flags[0];
                    next_st.dat[ucm_pkg::FLG_OVERRUN]  = st.err_flags[1];
                    next_st.dat[ucm_pkg::FLG_FRAMING]  = st.err_flags[2];
                    next_st.dat[ucm_pkg::FLG_PARITY]   = st.err_flags[3];
                    next_st.dat[ucm_pkg::FLG_TIMEOUT]  = st.timeout_flag;
                    next_st.dat[ucm_pkg::FLG_RETRY]    = st.retry_flag;
                    next_st.dat[ucm_pkg::FLG_NAK]      = st.nak_flag;
                end
                ucm_pkg::OFS_RX_HOLD:   next_st.dat = st.rx_hold;
                ucm_pkg::OFS_BAUD:      next_st.dat = st.baud;
                ucm_pkg::OFS_IDLE_TO:   next_st.dat = st.idle_to;
                ucm_pkg::OFS_GUARD:     next_st.dat = st.guard;
                ucm_pkg::OFS_CARD_CLK:  next_st.dat = st.card_clk;
                ucm_pkg::OFS_ERR_CNT:   next_st.dat = {24'h0, err_count_i};
                ucm_pkg::OFS_CTRL_STATE:
                    next_st.dat = {26'h0, st.rts_n, st.addr_pending,
                                   st.brk == ucm_pkg::BRK_TAIL, st.brk == ucm_pkg::BRK_SEND,
                                   st.tx_on, st.rx_on};
                ucm_pkg::OFS_IR_FILT:   next_st.dat = st.ir_filt;
                default:                next_st.dat = 32'h0000_0000;
            endcase
        end

        // resets return the enable of that side to off
        if (cmd[ucm_pkg::CMD_RX_RESET])
            next_st.rx_on = 1'b0;
        if (cmd[ucm_pkg::CMD_TX_RESET])
        begin
            next_st.tx_on = 1'b0;
            next_st.brk = ucm_pkg::BRK_IDLE;
            next_st.brk_min_done = 1'b0;
            next_st.tail_cnt = 4'h0;
            next_st.addr_pending = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.card_clk <= ucm_pkg::RST_CARD_CLK;
            st.rts_n <= 1'b1;
            st.brk <= ucm_pkg::BRK_IDLE;
            st.mode.mode_valid <= 1'b1;
            st.mode.parity_on <= 1'b1;
            st.mode.stop_valid <= 1'b1;
            st.mode.char_bits <= 4'h5;
        end
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign wb_dat_o = st.dat;
    assign wb_ack_o = st.ack;
    assign mode_o = st.mode;
    assign tx_data_o = st.tx_data;
    assign tx_valid_o = st.tx_valid;
    assign baud_divider_o = st.baud;
    assign idle_timeout_o = st.idle_to;
    assign guard_time_o = st.guard;
    assign card_ratio_o = st.card_clk;
    assign ir_filter_o = st.ir_filt;
    assign irq_mask_o = st.irq_state;
    assign ctrl_o = '{rx_reset: st.rx_reset, tx_reset: st.tx_reset, rx_enable: st.rx_on,
                      tx_enable: st.tx_on, break_active: st.brk[1],
                      break_tail: st.brk[2], timeout_wait: st.to_wait,
                      timeout_restart: st.to_restart, addr_next: st.addr_pending,
                      rts_n: st.rts_n};

endmodule // ucm_top

// ===== inc/ucm_pkg.sv
// shared constants and types for the serial control and mode interface
package ucm_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_COMMAND   = 8'h00;
    localparam logic [7:0] OFS_MODE      = 8'h04;
    localparam logic [7:0] OFS_IRQ_SET   = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATE = 8'h10;
    localparam logic [7:0] OFS_FLAGS     = 8'h14;
    localparam logic [7:0] OFS_RX_HOLD   = 8'h18;
    localparam logic [7:0] OFS_TX_HOLD   = 8'h1C;
    localparam logic [7:0] OFS_BAUD      = 8'h20;
    localparam logic [7:0] OFS_IDLE_TO   = 8'h24;
    localparam logic [7:0] OFS_GUARD     = 8'h28;
    localparam logic [7:0] OFS_CARD_CLK  = 8'h40;
    localparam logic [7:0] OFS_ERR_CNT   = 8'h44;
    localparam logic [7:0] OFS_IR_FILT   = 8'h4C;
    // control state word of my own choosing, read-only mirror of the enables, break states, address pending and rts level
    localparam logic [7:0] OFS_CTRL_STATE = 8'h50;

    // command bit positions
    localparam int CMD_RX_RESET    = 2;
    localparam int CMD_TX_RESET    = 3;
    localparam int CMD_RX_ON       = 4;
    localparam int CMD_RX_OFF      = 5;
    localparam int CMD_TX_ON       = 6;
    localparam int CMD_TX_OFF      = 7;
    localparam int CMD_ERR_CLR     = 8;
    localparam int CMD_BRK_BEGIN   = 9;
    localparam int CMD_BRK_END     = 10;
    localparam int CMD_TO_WAIT     = 11;
    localparam int CMD_ADDR_CHAR   = 12;
    localparam int CMD_RETRY_CLR   = 13;
    localparam int CMD_NAK_CLR     = 14;
    localparam int CMD_TO_RESTART  = 15;
    localparam int CMD_RTS_LOW     = 18;
    localparam int CMD_RTS_HIGH    = 19;

    // flag bit positions in the channel flags word
    localparam int FLG_RX_BREAK  = 2;
    localparam int FLG_OVERRUN   = 5;
    localparam int FLG_FRAMING   = 6;
    localparam int FLG_PARITY    = 7;
    localparam int FLG_TIMEOUT   = 8;
    localparam int FLG_RETRY     = 10;
    localparam int FLG_NAK       = 13;

    // reset values and write masks
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [31:0] RST_CARD_CLK = 32'h0000_0174;
    localparam logic [31:0] MODE_WMASK   = 32'h173F_FFFF;
    localparam logic [31:0] IRQ_WMASK    = 32'h0008_3FFF;

    // 12 bit periods of idle after a break
    localparam logic [3:0]  BRK_TAIL_BITS = 4'hC;

    typedef enum logic [3:0] {
        OPM_NORMAL    = 4'h0,
        OPM_RS485     = 4'h1,
        OPM_HANDSHAKE = 4'h2,
        OPM_CARD_T0   = 4'h4,
        OPM_CARD_T1   = 4'h6,
        OPM_INFRARED  = 4'h8
    } ucm_opmode_type;

    typedef enum logic [1:0] {
        CLK_MASTER = 2'h0,
        CLK_DIV    = 2'h1,
        CLK_RSVD   = 2'h2,
        CLK_EXT    = 2'h3
    } ucm_clksrc_type;

    // decoded mode word
    typedef struct packed {
        logic [3:0] opmode;
        logic [1:0] baud_source_select;
        logic [3:0] char_bits;
        logic [1:0] channel_loop_mode;
        logic [2:0] parity_select;
        logic       multidrop;
        logic       parity_on;
        logic [1:0] stop_bits_select;
        logic       stop_valid;
        logic       card_mode;
        logic       mode_valid;
    } ucm_mode_type;

    // command pulses and control levels towards the transceiver core
    typedef struct packed {
        logic rx_reset;
        logic tx_reset;
        logic rx_enable;
        logic tx_enable;
        logic break_active;
        logic break_tail;
        logic timeout_wait;
        logic timeout_restart;
        logic addr_next;
        logic rts_n;
    } ucm_ctrl_type;

    typedef enum logic [2:0] {
        BRK_IDLE = 3'b001,
        BRK_SEND = 3'b010,
        BRK_TAIL = 3'b100
    } ucm_brk_type;

endpackage

// ===== test/ucm_monitor.sv
// concurrent checks on the register bus and command outputs
`timescale 1ns/10ps
module ucm_monitor (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_we_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic [31:0]           wb_dat_o,
    input  wire logic                  wb_ack_o,
    input  wire logic                  tx_idle_i,
    input  wire ucm_pkg::ucm_ctrl_type ctrl_o,
    input  wire logic [8:0]            tx_data_o,
    input  wire logic                  tx_valid_o
);
    logic tk;
    logic cmd;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign tk  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmd = tk && wb_we_i && wb_adr_i == ucm_pkg::OFS_COMMAND && wb_sel_i == 4'hF;
    ////////////////////////////////////////////////////////////////////////////
    ack_one_cycle_a: assert property (tk |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");
    rx_reset_a: assert property (cmd && wb_dat_i[2] |=> ctrl_o.rx_reset ##1 !ctrl_o.rx_reset)
        else $error("receiver reset pulse wrong");
    no_stray_reset_a: assert property (!cmd |=> !ctrl_o.rx_reset && !ctrl_o.tx_reset)
        else $error("reset pulse without command");
    rx_off_a: assert property (cmd && wb_dat_i[5] |=> !ctrl_o.rx_enable)
        else $error("receiver still on after off command");
    tx_on_a: assert property (cmd && wb_dat_i[6] && !wb_dat_i[7] && !wb_dat_i[3]
        |=> ctrl_o.tx_enable)
        else $error("transmitter not on after on command");
    rts_pin_a: assert property (cmd && (wb_dat_i[18] || wb_dat_i[19])
        |=> ctrl_o.rts_n == $past(wb_dat_i[19]))
        else $error("rts pin level wrong after command");
    rsvd_read_a: assert property (tk && !wb_we_i && wb_adr_i inside {[8'h2C:8'h3C], 8'h48}
        |=> wb_dat_o == 32'h0)
        else $error("reserved offset read not zero");
    brk_after_idle_a: assert property ($rose(ctrl_o.break_active) |-> $past(tx_idle_i))
        else $error("break started while transmitter busy");
    tx_char_a: assert property (tk && wb_we_i && wb_adr_i == ucm_pkg::OFS_TX_HOLD
        |=> tx_valid_o && tx_data_o[7:0] == $past(wb_dat_i[7:0]))
        else $error("transmit character not passed on");
    to_wait_a: assert property (cmd && wb_dat_i[11] |=> ctrl_o.timeout_wait)
        else $error("time-out wait pulse missing");
endmodule // ucm_monitor

bind ucm_top ucm_monitor ucm_monitor_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .tx_idle_i, .ctrl_o, .tx_data_o,
    .tx_valid_o);

// ===== test/ucm_partner.sv
// transmit core model: busy after each character, bit and character ticks
`timescale 1ns/10ps
module ucm_partner (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic tx_valid_i,
    output logic      tx_idle_o,
    output logic      char_time_o,
    output logic      bit_tick_o
);
    logic [4:0] busy;
    logic [1:0] div;
    logic [3:0] bits;
    assign tx_idle_o   = (busy == 5'h00);
    assign bit_tick_o  = (div == 2'h3);
    assign char_time_o = bit_tick_o && (bits == 4'h9);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy <= 5'h00;
            div  <= 2'h0;
            bits <= 4'h0;
        end
        else
        begin
            // a slow core: 24 cycles, six bit periods, of drain per write
            busy <= tx_valid_i ? 5'h18 : busy - (busy != 5'h00);
            div  <= div + 2'h1;
            if (bit_tick_o)
                bits <= (bits == 4'h9) ? 4'h0 : bits + 4'h1;
        end
    end
endmodule // ucm_partner

// ===== test/ucm_top_bench.sv
// self-checking bench for the serial control and mode registers
`timescale 1ns/10ps
module ucm_top_bench;
    logic                  clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0;
    logic                  wb_cyc_i = 1'b0, wb_stb_i = 1'b0, rx_char_i = 1'b0;
    logic [7:0]            wb_adr_i = 8'h00, err_count_i = 8'h00;
    logic [31:0]           wb_dat_i = 32'h0, wb_dat_o, v, m;
    logic [3:0]            wb_sel_i = 4'hF, err_event_i = 4'h0;
    logic                  timeout_event_i = 1'b0, retry_event_i = 1'b0, nak_event_i = 1'b0;
    logic [8:0]            rx_data_i = 9'h000, tx_data_o;
    logic                  rx_valid_i = 1'b0, wb_ack_o, tx_valid_o, tx_idle_i;
    logic                  char_time_i, bit_tick_i;
    ucm_pkg::ucm_ctrl_type ctrl_o;
    ucm_pkg::ucm_mode_type mode_o;
    logic [31:0]           baud_divider_o, idle_timeout_o, guard_time_o, card_ratio_o;
    logic [31:0]           ir_filter_o, irq_mask_o;
    logic [32:0]           rd_q[$];
    logic [32:0]           hd;
    logic [8:0]            tx_q[$];
    int                    fail_count = 0, cmp_count = 0, n;
    logic [7:0]            rst_adr[10] = '{8'h04, 8'h10, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C,
                                           8'h40, 8'h48, 8'h4C};
    logic [7:0]            rw_adr[5] = '{8'h20, 8'h24, 8'h28, 8'h40, 8'h4C};
    logic [3:0]            opm[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
    always #20 clk_i = ~clk_i;
    ucm_top ucm_top_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
        .wb_stb_i, .wb_dat_o, .wb_ack_o, .tx_idle_i, .char_time_i, .bit_tick_i, .rx_char_i,
        .err_event_i, .timeout_event_i, .retry_event_i, .nak_event_i, .rx_data_i, .rx_valid_i,
        .err_count_i, .ctrl_o, .mode_o, .tx_data_o, .tx_valid_o, .baud_divider_o,
        .idle_timeout_o, .guard_time_o, .card_ratio_o, .ir_filter_o, .irq_mask_o);
    ucm_partner ucm_partner_i (.clk_i, .rst_i, .tx_valid_i(tx_valid_o), .tx_idle_o(tx_idle_i),
        .char_time_o(char_time_i), .bit_tick_o(bit_tick_i));
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic guard(input int k);
        if (k >= 400)
        begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    // one classic cycle; note says whether read data is to be checked
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] note);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        rd_q.push_back(note);
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 400);
        guard(k);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, {1'b1, e});
    endtask
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && rd_q.size() > 0)
        begin
            hd = rd_q.pop_front();
            if (hd[32])
                cmp("read data", hd[31:0], wb_dat_o);
        end
        if (tx_valid_o === 1'b1)
            cmp("tx char", tx_q.size() ? tx_q.pop_front() : 32'h1FF, tx_data_o);
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        v = $urandom(32'hA348);
        err_count_i = $urandom();
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rst_adr[i])
            rd(rst_adr[i], rst_adr[i] == 8'h40 ? ucm_pkg::RST_CARD_CLK : ucm_pkg::RST_ZERO);
        $display("reset values done");
        foreach (rw_adr[i])
        begin
            v = $urandom();
            wr(rw_adr[i], v);
            wr(8'h2C, ~v);
            rd(rw_adr[i], v);
        end
        rd(8'h2C, 32'h0);
        cmp("filter port", v, ir_filter_o);
        wr(8'h08, v);
        wr(8'h0C, 32'h1);
        wr(8'h10, 32'h0);
        rd(8'h10, v & ucm_pkg::IRQ_WMASK & ~32'h1);
        cmp("irq port", v & ucm_pkg::IRQ_WMASK & ~32'h1, irq_mask_o);
        rd(8'h44, {24'h0, err_count_i});
        $display("register access done");
        foreach (opm[i])
        begin
            m = (i == 5 ? 32'h0002_0000 : 32'h0) | (i % 4) << 14 | i << 9 | (i % 4) << 6
                | (i % 4) << 4 | opm[i];
            wr(ucm_pkg::OFS_MODE, m);
            rd(ucm_pkg::OFS_MODE, m & ucm_pkg::MODE_WMASK);
            cmp("opmode", opm[i], mode_o.opmode);
            cmp("clock src", (i % 4 == 2) ? 0 : i % 4, mode_o.baud_source_select);
            cmp("char bits", (i == 5) ? 9 : 5 + i % 4, mode_o.char_bits);
            cmp("loop mode", i % 4, mode_o.channel_loop_mode);
            cmp("parity on", i < 4, mode_o.parity_on);
        end
        $display("mode decode done");
        wr(8'h00, 32'h10);
        cmp("rx on", 1, ctrl_o.rx_enable);
        wr(8'h00, 32'h30);
        cmp("rx off wins", 0, ctrl_o.rx_enable);
        wr(8'h00, 32'h50);
        cmp("tx on", 1, ctrl_o.tx_enable);
        wr(8'h00, 32'hC0);
        cmp("tx off wins", 0, ctrl_o.tx_enable);
        wr(8'h00, 32'h10);
        wr(8'h00, 32'h0C);
        cmp("rx after reset", 0, ctrl_o.rx_enable);
        wr(8'h00, 32'h0004_0000);
        cmp("rts low", 0, ctrl_o.rts_n);
        wr(8'h00, 32'h000C_0000);
        cmp("rts high", 1, ctrl_o.rts_n);
        $display("commands done");
        @(posedge clk_i);
        {err_event_i, timeout_event_i, retry_event_i, nak_event_i} <= 7'h7F;
        rx_data_i <= $urandom();
        rx_valid_i <= 1'b1;
        @(posedge clk_i);
        {err_event_i, timeout_event_i, retry_event_i, nak_event_i} <= 7'h00;
        rx_valid_i <= 1'b0;
        rd(8'h18, {23'h0, rx_data_i});
        rd(8'h14, 32'h0000_25E4);
        wr(8'h00, 32'h0000_6900);
        rd(8'h14, 32'h0000_0400);
        wr(ucm_pkg::OFS_MODE, 32'h4);
        wr(8'h00, 32'h0000_2000);
        rd(8'h14, 32'h0);
        $display("flags done");
        wr(ucm_pkg::OFS_MODE, 32'h0C00);
        wr(8'h00, 32'h1000);
        tx_q = '{9'h155, 9'h0AA};
        wr(8'h1C, 32'h55);
        wr(8'h1C, 32'hAA);
        wr(ucm_pkg::OFS_MODE, 32'h0);
        wr(8'h00, 32'h1000);
        tx_q.push_back(9'h033);
        wr(8'h1C, 32'h33);
        wr(8'h00, 32'h0200);
        cmp("break waits", 0, ctrl_o.break_active);
        for (n = 0; ctrl_o.break_active !== 1'b1 && n < 400; n++)
            @(posedge clk_i);
        guard(n);
        wr(8'h00, 32'h0400);
        for (n = 0; ctrl_o.break_tail !== 1'b1 && n < 400; n++)
            @(posedge clk_i);
        guard(n);
        v = 0;
        for (n = 0; ctrl_o.break_tail === 1'b1 && n < 400; n++)
        begin
            v += bit_tick_i;
            @(posedge clk_i);
        end
        guard(n);
        cmp("tail bits", ucm_pkg::BRK_TAIL_BITS, v);
        $display("break done");
        tally_and_finish();
    end
endmodule // ucm_top_bench
